// ### fpb_consts.svh
// Purpose: Offsets, fields, reset values and timing of the fan block
// Assumes: 100 MHz clk, registers at their offsets on a 16-bit port
// Notes:   Definitions only
// Behaviour
// - Two-bit base select picks 26.83, 20.87, 4.82 or 2.41 kHz; resets 00.
// - Each event flag of the status register drives the interrupt only while its interrupt enable bit is set.
// - Bit 5 sets when speed cannot reach target at full drive.
// - Bit 1 sets when spin-up gets no valid reading in its window.
// - Bit 0 sets when the tachometer detects a stalled fan.
// - Reading above valid count means stall and starts spin-up automatically.
// - Shortfall check runs only while drive high byte is ffh.
// - Shortfall when speed at or below target minus band too long.
`ifndef FPB_CONSTS_SVH
`define FPB_CONSTS_SVH

`define FPB_OFF_VALID_CNT 8'h09
`define FPB_OFF_FAIL_BAND 8'h0a
`define FPB_OFF_TARGET    8'h0c
`define FPB_OFF_BASE      8'h10
`define FPB_OFF_STATUS    8'h11
`define FPB_OFF_CONFIG    8'h12
`define FPB_OFF_IRQ_EN    8'h13
`define FPB_OFF_CLEAR     8'h14

`define FPB_BIT_STALL     0
`define FPB_BIT_SPIN      1
`define FPB_BIT_DRV_FAIL  5
`define FPB_STATUS_MASK   8'h23

`define FPB_RST_BASE      2'h0
`define FPB_RST_VALID_CNT 8'hf5
`define FPB_RST_FAIL_BAND 13'h0000
`define FPB_RST_TARGET    13'h1fff
`define FPB_RST_CONFIG    2'h0
`define FPB_FULL_DRIVE    8'hff

`define FPB_CLK_HZ        100000000
`define FPB_FREQ0_HZ      26830
`define FPB_FREQ1_HZ      20870
`define FPB_FREQ2_HZ      4820
`define FPB_FREQ3_HZ      2410
`define FPB_SPIN_WINDOW_MS 500
`define FPB_SPIN_CYCLES   (`FPB_SPIN_WINDOW_MS * (`FPB_CLK_HZ / 1000))
`define FPB_FAIL_MIN_SAMPLES 16

`endif

// ### fpb_pkg.sv
// Purpose: Types shared by the fan base and status block
// Assumes: Constants come from fpb_consts.svh
// Notes:   Types only
package fpb_pkg;

    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } fpb_req_t;

    typedef struct packed {
        logic [12:0] reading;
        logic        valid;
    } fpb_tach_t;

    typedef enum logic [0:0] {
        FPB_RUN,
        FPB_SPIN_UP
    } fpb_state_t;

endpackage

// ### fpb_fan_status.sv
// Purpose: PWM base range select and sticky fan event flags with interrupt
// Assumes: Tach samples and drive setting come from logic on clk
// Notes:   One-cycle read latency; writes take effect on the next edge, pwm_period and irq one edge later
`include "fpb_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module fpb_fan_status
    import fpb_pkg::*;
#(
    parameter int unsigned SPIN_CYCLES = `FPB_SPIN_CYCLES
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        srst,

    // Register port
    input  wire fpb_req_t    req,
    output var  logic [15:0] rd_data,

    // Fan unit side
    input  wire fpb_tach_t   tach,
    input  wire logic [7:0]  drive_hi,
    output var  logic [1:0]  pwm_base_sel,
    output var  logic [15:0] pwm_period,
    output var  logic        spin_up_start,

    // Interrupt
    output var  logic        irq
);

    function automatic logic [15:0] base_period(input logic [1:0] sel);
        logic [31:0] hz;
        hz = 32'(`FPB_FREQ0_HZ);
        unique case (sel)
            2'h0: hz = 32'(`FPB_FREQ0_HZ);
            2'h1: hz = 32'(`FPB_FREQ1_HZ);
            2'h2: hz = 32'(`FPB_FREQ2_HZ);
            2'h3: hz = 32'(`FPB_FREQ3_HZ);
        endcase
        return 16'(32'(`FPB_CLK_HZ) / hz);
    endfunction

    function automatic logic wr_hit(input fpb_req_t r,
                                    input logic [7:0] off);
        return r.wr && (r.addr == off);
    endfunction

    logic [7:0]  valid_cnt;
    logic [12:0] fail_band;
    logic [12:0] target;
    logic [1:0]  fail_sel;
    logic [7:0]  status;
    logic [7:0]  irq_en;
    logic [7:0]  event_set;
    logic [7:0]  clear_bits;
    logic [7:0]  next_status;
    logic        stalled;
    logic        shortfall;
    logic [7:0]  fail_cnt;
    logic [7:0]  fail_limit;
    logic [31:0] spin_cnt;
    logic        spin_fail;
    logic        drv_fail;
    fpb_state_t  state;

    // Base range select
    always_ff @(posedge clk) begin
        if (srst) begin
            pwm_base_sel <= `FPB_RST_BASE;
        end else if (wr_hit(req, `FPB_OFF_BASE)) begin
            pwm_base_sel <= req.wdata[1:0];
        end
    end

    // Period follows the select one cycle later
    always_ff @(posedge clk) begin
        if (srst) begin
            pwm_period <= base_period(`FPB_RST_BASE);
        end else begin
            pwm_period <= base_period(pwm_base_sel);
        end
    end

    // Detection thresholds and interrupt enable
    always_ff @(posedge clk) begin
        if (srst) begin
            valid_cnt <= `FPB_RST_VALID_CNT;
            fail_band <= `FPB_RST_FAIL_BAND;
            target    <= `FPB_RST_TARGET;
            fail_sel  <= `FPB_RST_CONFIG;
            irq_en    <= 8'h00;
        end else begin
            if (wr_hit(req, `FPB_OFF_VALID_CNT)) begin
                valid_cnt <= req.wdata[7:0];
            end
            if (wr_hit(req, `FPB_OFF_FAIL_BAND)) begin
                fail_band <= req.wdata[15:3];
            end
            if (wr_hit(req, `FPB_OFF_TARGET)) begin
                target <= req.wdata[15:3];
            end
            if (wr_hit(req, `FPB_OFF_CONFIG)) begin
                fail_sel <= req.wdata[1:0];
            end
            if (wr_hit(req, `FPB_OFF_IRQ_EN)) begin
                irq_en <= req.wdata[7:0] & `FPB_STATUS_MASK;
            end
        end
    end

    // Valid count covers the top eight bits of the reading
    assign stalled = tach.valid && (tach.reading[12:5] > valid_cnt);

    // Larger count means slower fan, so target minus band is target plus band
    assign shortfall = ({1'b0, tach.reading} >=
                        ({1'b0, target} + {1'b0, fail_band}));

    assign fail_limit = 8'(`FPB_FAIL_MIN_SAMPLES) << fail_sel;

    // Shortfall persistence counted in tach samples
    always_ff @(posedge clk) begin
        if (srst) begin
            fail_cnt <= 8'h00;
            drv_fail <= 1'b0;
        end else begin
            drv_fail <= 1'b0;
            if (drive_hi != `FPB_FULL_DRIVE) begin
                fail_cnt <= 8'h00;
            end else if (tach.valid) begin
                if (!shortfall) begin
                    fail_cnt <= 8'h00;
                end else if (fail_cnt >= fail_limit) begin
                    drv_fail <= 1'b1;
                    fail_cnt <= 8'h00;
                end else begin
                    fail_cnt <= fail_cnt + 8'h01;
                end
            end
        end
    end

    // Spin-up supervision; a stall during spin-up does not restart it
    always_ff @(posedge clk) begin
        if (srst) begin
            state         <= FPB_RUN;
            spin_cnt      <= 32'h0;
            spin_up_start <= 1'b0;
            spin_fail     <= 1'b0;
        end else begin
            spin_up_start <= 1'b0;
            spin_fail     <= 1'b0;
            unique case (state)
                FPB_RUN: begin
                    spin_cnt <= 32'h0;
                    if (stalled) begin
                        state         <= FPB_SPIN_UP;
                        spin_up_start <= 1'b1;
                    end
                end
                FPB_SPIN_UP: begin
                    spin_cnt <= spin_cnt + 32'h1;
                    if (tach.valid && !stalled) begin
                        state <= FPB_RUN;
                    end else if (spin_cnt >= SPIN_CYCLES - 1) begin
                        state     <= FPB_RUN;
                        spin_fail <= 1'b1;
                    end
                end
            endcase
        end
    end

    always_comb begin
        event_set = 8'h00;
        event_set[`FPB_BIT_STALL]    = stalled;
        event_set[`FPB_BIT_SPIN]     = spin_fail;
        event_set[`FPB_BIT_DRV_FAIL] = drv_fail;
    end

    // Either the status offset or the clear offset clears by writing ones
    always_comb begin
        clear_bits = 8'h00;
        if (wr_hit(req, `FPB_OFF_STATUS) || wr_hit(req, `FPB_OFF_CLEAR)) begin
            clear_bits = req.wdata[7:0];
        end
        next_status = ((status & ~clear_bits) | event_set) &
                      `FPB_STATUS_MASK;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            status <= 8'h00;
        end else begin
            status <= next_status;
        end
    end

    // Registered, so it lags the flag by one cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status & irq_en);
        end
    end

    // Read port; unmapped and write-only offsets read zero
    always_ff @(posedge clk) begin
        if (srst) begin
            rd_data <= 16'h0000;
        end else if (req.rd) begin
            unique case (req.addr)
                `FPB_OFF_VALID_CNT: rd_data <= {8'h00, valid_cnt};
                `FPB_OFF_FAIL_BAND: rd_data <= {fail_band, 3'h0};
                `FPB_OFF_TARGET:    rd_data <= {target, 3'h0};
                `FPB_OFF_BASE:      rd_data <= {14'h0000, pwm_base_sel};
                `FPB_OFF_STATUS:    rd_data <= {8'h00, status};
                `FPB_OFF_CONFIG:    rd_data <= {14'h0000, fail_sel};
                `FPB_OFF_IRQ_EN:    rd_data <= {8'h00, irq_en};
                default:            rd_data <= 16'h0000;
            endcase
        end else begin
            rd_data <= 16'h0000;
        end
    end

endmodule

`default_nettype wire

// ### fpb_fan_asserts.sv
// Purpose: Port checks for fpb_fan_status
// Assumes: Valid count left at its reset value f5
// Notes:   Bound to the design below
`timescale 1ns/1ps
`default_nettype none
module fpb_fan_asserts
    import fpb_pkg::*;
(
    // Watched ports
    input wire logic        clk,
    input wire logic        srst,
    input wire fpb_req_t    req,
    input wire logic [15:0] rd_data,
    input wire fpb_tach_t   tach,
    input wire logic [1:0]  pwm_base_sel,
    input wire logic [15:0] pwm_period,
    input wire logic        spin_up_start,
    input wire logic        irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    function automatic logic [15:0] per(logic [1:0] s);
        return s == 2'h0 ? 16'h0e8f : s == 2'h1 ? 16'h12b7 :
               s == 2'h2 ? 16'h510a : 16'ha215;
    endfunction
    sequence base_wr;
        req.wr && req.addr == 8'h10;
    endsequence
    sequence stall_smp;
        tach.valid && tach.reading[12:5] > 8'hf5;
    endsequence
    base_reset_a: assert property ($past(srst) |-> !pwm_base_sel && !irq)
        else $error("reset values wrong");
    base_write_a: assert property (base_wr |=>
        pwm_base_sel == $past(req.wdata[1:0]) ##1
        pwm_period == per($past(pwm_base_sel)))
        else $error("base write lost");
    base_hold_a: assert property (!req.wr || req.addr != 8'h10 |=>
        $stable(pwm_base_sel))
        else $error("base changed alone");
    period_map_a: assert property (pwm_period == per($past(pwm_base_sel)))
        else $error("period mismatch");
    spin_cause_a: assert property ($rose(spin_up_start) |->
        $past(tach.valid) && $past(tach.reading[12:5]) > 8'hf5)
        else $error("spin-up without stall");
    spin_pulse_a: assert property (spin_up_start |=> !spin_up_start)
        else $error("spin-up pulse too long");
    rd_idle_a: assert property (!$past(req.rd) |-> rd_data == 16'h0000)
        else $error("read data outside slot");
    rd_mask_a: assert property ($past(req.rd && req.addr == 8'h11) |->
        (rd_data & 16'hffdc) == 16'h0000)
        else $error("reserved status bits set");
    stall_c: cover property (stall_smp ##1 spin_up_start);
endmodule
bind fpb_fan_status fpb_fan_asserts u_chk (.clk, .srst, .req, .rd_data,
    .tach, .pwm_base_sel, .pwm_period, .spin_up_start, .irq);
`default_nettype wire

// ### fpb_fan_model.sv
// Purpose: Fan with tach feedback, one sample each 8 clocks
// Assumes: Bench sets the count the fan reports
// Notes:   Between samples the reading shows the inverse, not stale
`timescale 1ns/1ps
`default_nettype none
module fpb_fan_model
    import fpb_pkg::*;
(
    // Clock and setting
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic [12:0] count,
    // Tach feedback
    output var  fpb_tach_t   tach
);
    logic [2:0] phase;
    always_ff @(posedge clk) begin
        phase <= srst ? 3'h0 : phase + 3'h1;
        tach.valid <= !srst && phase == 3'h7;
        tach.reading <= phase == 3'h7 ? count : ~count;
    end
endmodule
`default_nettype wire

// ### fpb_fan_status_bench.sv
// Purpose: Self-checking bench for fpb_fan_status
// Assumes: Spin window shortened to 20 cycles
// Notes:   Tasks start and end 1 ns after a clock edge
`timescale 1ns/1ps
`default_nettype none
module fpb_fan_status_bench;
    import fpb_pkg::*;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    fpb_req_t    req = '0;
    fpb_tach_t   tach;
    logic [12:0] count = 13'h0100;
    logic [7:0]  drive_hi = 8'h00;
    logic [15:0] rd_data;
    logic [15:0] pwm_period;
    logic [1:0]  pwm_base_sel;
    logic        spin_up_start;
    logic        irq;
    int          bad_count = 0;
    int          n_checks = 0;
    always #5 clk = ~clk;
    fpb_fan_status #(.SPIN_CYCLES(20)) u_dut (.clk, .srst, .req, .rd_data,
        .tach, .drive_hi, .pwm_base_sel, .pwm_period, .spin_up_start, .irq);
    fpb_fan_model u_fan (.clk, .srst, .count, .tach);
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic check(input logic ok, input string w);
        n_checks++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("MISMATCH %0t %s", $time, w);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    // Release then let an edge pass, so no signal is driven twice at once
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        tick(1);
        req <= '0;
        tick(1);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [15:0] e, string w);
        req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        tick(1);
        check(rd_data === e, w);
        req <= '0;
        tick(1);
    endtask
    task automatic t_reset();
        rdc(8'h10, 16'h0000, "base reset");
        rdc(8'h11, 16'h0000, "status reset");
        rdc(8'h20, 16'h0000, "unmapped read");
    endtask
    task automatic t_base();
        logic [15:0] per [4] = '{16'h0e8f, 16'h12b7, 16'h510a, 16'ha215};
        for (int i = 0; i < 4; i++) begin
            wr(8'h10, 16'hfffc | 16'(i));
            check(pwm_base_sel === 2'(i), "base select");
            rdc(8'h10, 16'(i), "base readback");
            check(pwm_period === per[i], "base period");
        end
    endtask
    task automatic t_stall();
        int n;
        wr(8'h13, 16'h0023);
        count <= 13'h1fff;
        for (n = 0; n < 40 && spin_up_start !== 1'b1; n++) tick(1);
        check(n < 40, "no spin-up start");
        tick(1);
        check(irq === 1'b1, "stall irq");
        tick(30);
        rdc(8'h11, 16'h0003, "stall and spin flags");
        count <= 13'h0100;
        wr(8'h13, 16'h0000);
        tick(10);
        check(irq === 1'b0, "irq not masked");
        wr(8'h14, 16'h0023);
        rdc(8'h11, 16'h0000, "flags not cleared");
        wr(8'h13, 16'h0023);
        tick(1);
        check(irq === 1'b0, "irq without flag");
    endtask
    task automatic t_fail();
        wr(8'h0c, 16'h4000);
        // Slower than target, but not slow enough to count as stalled
        count <= 13'h0900;
        tick(160);
        rdc(8'h11, 16'h0000, "fail below full drive");
        drive_hi <= 8'hff;
        tick(96);
        rdc(8'h11, 16'h0000, "fail too early");
        tick(64);
        rdc(8'h11, 16'h0020, "drive fail flag");
        check(irq === 1'b1, "fail irq");
    endtask
    initial begin
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        tick(1);
        t_reset();
        t_base();
        t_stall();
        t_fail();
        summarize();
    end
    initial begin
        #50000;
        bad_count++;
        summarize();
    end
endmodule
`default_nettype wire
